//--- acr_core_ctrl.sv
// Purpose: control register group of a stereo class-d amplifier core
// Assumes: byte commands from the control-port engine on clk
// Notes:   reset requests are pulses, never stored
// How it works
// - core reset resets processor and all registers, clears coefficients.
// - register reset restores all registers; coefficient memory untouched.
// - both reset request bits are write-only and read back as zero.
// - bits 6-4 pick 768k/384k/310k/480k/576k switching; 101-111 reserved.
// - bit 2 selects bridge-tied-load when 0, parallel bridge when 1.
// - bits 1-0 select BD, one-sided pulse width, or low-idle modulation.
// - processor reset bit resets to 1; clearing it starts processor output.
// - mute bit ramps volume smoothly down; clearing ramps it back up.
// - bits 1-0 pick deep sleep, sleep, high-z, play; reset is deep sleep.
// - wrap bit 0, nonzero book: page end continues at address 8, next page.
// - wrap bit 1: page end returns to address 0 of same page.
`timescale 1ns/1ns
`default_nettype none
module acr_core_ctrl #(
  parameter int GAIN_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire acr_pkg::acr_cmd_type cmd,
  input  wire logic [7:0]        book,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic [7:0]             cur_page,
  output logic [7:0]             cur_addr,
  output logic                   core_reset_pulse,
  output logic [2:0]             switching_frequency_field,
  output logic                   bridge_config_bit,
  output logic [1:0]             modulation_field,
  output logic                   processor_reset_bit,
  output logic                   mute_req,
  output logic [1:0]             power_state,
  output logic                   page_wrap_bit,
  output logic [GAIN_W-1:0]      gain
);

  localparam logic [GAIN_W-1:0] GAIN_MAX = {GAIN_W{1'b1}};
  localparam logic [GAIN_W-1:0] GAIN_MIN = '0;
  localparam logic [GAIN_W-1:0] GAIN_ONE = GAIN_W'(1);
  localparam logic [15:0] STEP_LAST = 16'(acr_pkg::ACR_RAMP_STEP_CYC - 1);

  logic [7:0]        config_q;
  logic [7:0]        power_q;
  logic [7:0]        wrap_q;
  logic [7:0]        addr_q;
  logic [7:0]        page_q;
  logic [7:0]        rdata_q;
  logic              rvalid_q;
  logic              core_pulse_q;
  logic [GAIN_W-1:0] gain_q;
  logic [15:0]       step_q;

  // decode
  wire ctrl_sel = (page_q == acr_pkg::ACR_CTRL_PAGE)
                  && (book == acr_pkg::ACR_CTRL_BOOK);
  wire is_wr    = cmd.valid && (cmd.kind == acr_pkg::ACR_CMD_WRITE);
  wire is_rd    = cmd.valid && (cmd.kind == acr_pkg::ACR_CMD_READ);
  wire is_set   = cmd.valid && (cmd.kind == acr_pkg::ACR_CMD_SETADDR);
  wire reg_wr   = is_wr && ctrl_sel;
  wire wr_reset = reg_wr && (addr_q == acr_pkg::ACR_OFS_RESET);
  wire wr_cfg   = reg_wr && (addr_q == acr_pkg::ACR_OFS_CONFIG);
  wire wr_pwr   = reg_wr && (addr_q == acr_pkg::ACR_OFS_POWER);
  wire wr_wrap  = reg_wr && (addr_q == acr_pkg::ACR_OFS_WRAP);
  wire core_req = wr_reset && cmd.data[acr_pkg::ACR_CORE_RST_BIT];
  wire regs_req = wr_reset && cmd.data[acr_pkg::ACR_REG_RST_BIT];
  wire any_rst  = core_req || regs_req;

  // read mux; reset request register always reads zero
  wire [7:0] rd_mux =
    !ctrl_sel                            ? acr_pkg::ACR_ZERO_BYTE :
    (addr_q == acr_pkg::ACR_OFS_CONFIG) ? config_q :
    (addr_q == acr_pkg::ACR_OFS_POWER)  ? power_q  :
    (addr_q == acr_pkg::ACR_OFS_WRAP)   ? wrap_q   :
                                          acr_pkg::ACR_ZERO_BYTE;

  // auto-increment; book 0 always wraps within its page
  wire at_end    = (addr_q == acr_pkg::ACR_PAGE_LAST);
  wire go_next   = (book != acr_pkg::ACR_CTRL_BOOK)
                   && !wrap_q[acr_pkg::ACR_WRAP_BIT];
  wire [7:0] addr_inc = at_end ? (go_next ? acr_pkg::ACR_PAGE_RESTART
                                          : acr_pkg::ACR_PAGE_FIRST)
                               : addr_q + 8'h01;
  wire [7:0] page_inc = (at_end && go_next) ? page_q + 8'h01 : page_q;

  // ramp target: full gain unless muted
  wire [GAIN_W-1:0] gain_tgt = power_q[acr_pkg::ACR_MUTE_BIT] ? GAIN_MIN
                                                             : GAIN_MAX;
  wire step_done = (step_q == STEP_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_q <= acr_pkg::ACR_RST_CONFIG;
      power_q  <= acr_pkg::ACR_RST_POWER;
      wrap_q   <= acr_pkg::ACR_RST_WRAP;
    end else if (clk_en) begin
      if (any_rst) begin
        config_q <= acr_pkg::ACR_RST_CONFIG;
        power_q  <= acr_pkg::ACR_RST_POWER;
        wrap_q   <= acr_pkg::ACR_RST_WRAP;
      end else begin
        if (wr_cfg) config_q <= cmd.data;
        if (wr_pwr) power_q  <= cmd.data;
        if (wr_wrap) wrap_q  <= cmd.data;
      end
    end
  end

  // pointer survives a register reset; it is not a control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= acr_pkg::ACR_PAGE_FIRST;
      page_q <= acr_pkg::ACR_CTRL_PAGE;
    end else if (clk_en) begin
      if (is_set) begin
        addr_q <= cmd.data;
        page_q <= cmd.page;
      end else if (is_wr || is_rd) begin
        addr_q <= addr_inc;
        page_q <= page_inc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q      <= acr_pkg::ACR_ZERO_BYTE;
      rvalid_q     <= 1'b0;
      core_pulse_q <= 1'b0;
    end else if (clk_en) begin
      rvalid_q     <= is_rd;
      core_pulse_q <= core_req;
      if (is_rd) rdata_q <= rd_mux;
    end
  end

  // one gain step per ramp interval avoids pops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_q <= GAIN_MIN;
      step_q <= '0;
    end else if (clk_en) begin
      if (gain_q == gain_tgt || step_done) step_q <= '0;
      else step_q <= step_q + 16'h0001;
      if (step_done && gain_q > gain_tgt) gain_q <= gain_q - GAIN_ONE;
      else if (step_done && gain_q < gain_tgt) gain_q <= gain_q + GAIN_ONE;
    end
  end

  assign rdata                     = rdata_q;
  assign rvalid                    = rvalid_q;
  assign cur_page                  = page_q;
  assign cur_addr                  = addr_q;
  assign core_reset_pulse          = core_pulse_q;
  assign switching_frequency_field =
    config_q[acr_pkg::ACR_FSW_MSB:acr_pkg::ACR_FSW_LSB];
  assign bridge_config_bit         = config_q[acr_pkg::ACR_BRIDGE_BIT];
  assign modulation_field          =
    config_q[acr_pkg::ACR_MOD_MSB:acr_pkg::ACR_MOD_LSB];
  assign processor_reset_bit       = power_q[acr_pkg::ACR_PROC_RST_BIT];
  assign mute_req                  = power_q[acr_pkg::ACR_MUTE_BIT];
  assign power_state               =
    power_q[acr_pkg::ACR_PSTATE_MSB:acr_pkg::ACR_PSTATE_LSB];
  assign page_wrap_bit             = wrap_q[acr_pkg::ACR_WRAP_BIT];
  assign gain                      = gain_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_core_req;
    clk_en && core_req;
  endsequence

  property p_core_reset;
    s_core_req |=> core_reset_pulse && processor_reset_bit
                   && power_state == acr_pkg::ACR_PS_DEEP_SLEEP;
  endproperty
  a_core_reset: assert property (p_core_reset)
    else $error("core reset did not reset processor and registers");

  property p_reg_reset;
    clk_en && regs_req && !core_req |=> !core_reset_pulse
      && config_q == acr_pkg::ACR_RST_CONFIG
      && power_q == acr_pkg::ACR_RST_POWER
      && wrap_q == acr_pkg::ACR_RST_WRAP;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset wrong or touched coefficient memory");

  property p_reset_reads_zero;
    clk_en && is_rd && ctrl_sel && addr_q == acr_pkg::ACR_OFS_RESET
      |=> rvalid && rdata == acr_pkg::ACR_ZERO_BYTE;
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero)
    else $error("reset request register did not read zero");

  property p_cfg_write;
    clk_en && wr_cfg |=> switching_frequency_field
      == $past(cmd.data[acr_pkg::ACR_FSW_MSB:acr_pkg::ACR_FSW_LSB])
      && bridge_config_bit == $past(cmd.data[acr_pkg::ACR_BRIDGE_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration fields not taken from write");

  property p_mod_hold;
    !(clk_en && (wr_cfg || any_rst)) |=> $stable(modulation_field);
  endproperty
  a_mod_hold: assert property (p_mod_hold)
    else $error("modulation field changed without a write");

  property p_pwr_write;
    clk_en && wr_pwr && !any_rst |=> power_state
      == $past(cmd.data[acr_pkg::ACR_PSTATE_MSB:acr_pkg::ACR_PSTATE_LSB])
      && processor_reset_bit == $past(cmd.data[acr_pkg::ACR_PROC_RST_BIT]);
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power state or processor reset not taken from write");

  property p_ramp;
    $changed(gain) |-> $past(step_done)
      && (gain == $past(gain) + GAIN_ONE || gain == $past(gain) - GAIN_ONE);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("gain jumped instead of ramping one step");

  sequence s_end_access;
    clk_en && (is_wr || is_rd) && at_end;
  endsequence

  property p_wrap_next;
    (s_end_access and go_next) |=> cur_addr == acr_pkg::ACR_PAGE_RESTART
      && cur_page == $past(page_q) + 8'h01;
  endproperty
  a_wrap_next: assert property (p_wrap_next)
    else $error("page end did not continue on next page");

  property p_wrap_same;
    (s_end_access and page_wrap_bit) |=> cur_addr == acr_pkg::ACR_PAGE_FIRST
      && $stable(cur_page);
  endproperty
  a_wrap_same: assert property (p_wrap_same)
    else $error("page end did not wrap to start of same page");

endmodule
`default_nettype wire

//--- acr_pkg.sv
// Purpose: constants and types shared by the amplifier control registers
// Assumes: 8-bit register port from the control-port byte engine
// Notes:   all offsets and field positions of the four registers
package acr_pkg;

  // register offsets in page 0 of book 0
  localparam logic [7:0] ACR_OFS_RESET = 8'h01;
  localparam logic [7:0] ACR_OFS_CONFIG = 8'h02;
  localparam logic [7:0] ACR_OFS_POWER = 8'h03;
  localparam logic [7:0] ACR_OFS_WRAP = 8'h0f;

  // reset values
  localparam logic [7:0] ACR_RST_CONFIG = 8'h00;
  localparam logic [7:0] ACR_RST_POWER = 8'h10;
  localparam logic [7:0] ACR_RST_WRAP = 8'h00;
  localparam logic [7:0] ACR_ZERO_BYTE = 8'h00;

  // field positions
  localparam int ACR_CORE_RST_BIT = 4;
  localparam int ACR_REG_RST_BIT = 0;
  localparam int ACR_FSW_LSB = 4;
  localparam int ACR_FSW_MSB = 6;
  localparam int ACR_BRIDGE_BIT = 2;
  localparam int ACR_MOD_LSB = 0;
  localparam int ACR_MOD_MSB = 1;
  localparam int ACR_PROC_RST_BIT = 4;
  localparam int ACR_MUTE_BIT = 3;
  localparam int ACR_PSTATE_LSB = 0;
  localparam int ACR_PSTATE_MSB = 1;
  localparam int ACR_WRAP_BIT = 3;

  // page addressing
  localparam logic [7:0] ACR_PAGE_LAST = 8'h7f;
  localparam logic [7:0] ACR_PAGE_RESTART = 8'h08;
  localparam logic [7:0] ACR_PAGE_FIRST = 8'h00;
  localparam logic [7:0] ACR_CTRL_PAGE = 8'h00;
  localparam logic [7:0] ACR_CTRL_BOOK = 8'h00;

  // soft mute ramp timing
  localparam int ACR_CLK_PERIOD_NS = 10;
  localparam int ACR_RAMP_STEP_NS = 1000;
  localparam int ACR_RAMP_STEP_CYC =
    (ACR_RAMP_STEP_NS + ACR_CLK_PERIOD_NS - 1) / ACR_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ACR_FSW_768K = 3'h0,
    ACR_FSW_384K = 3'h1,
    ACR_FSW_310K = 3'h2,
    ACR_FSW_480K = 3'h3,
    ACR_FSW_576K = 3'h4
  } acr_fsw_type;

  typedef enum logic [1:0] {
    ACR_MOD_BD          = 2'h0,
    ACR_MOD_ONE_SIDED   = 2'h1,
    ACR_MOD_LOW_IDLE    = 2'h2
  } acr_mod_type;

  typedef enum logic [1:0] {
    ACR_PS_DEEP_SLEEP = 2'h0,
    ACR_PS_SLEEP      = 2'h1,
    ACR_PS_HIZ        = 2'h2,
    ACR_PS_PLAY       = 2'h3
  } acr_pstate_type;

  typedef enum logic [1:0] {
    ACR_CMD_SETADDR = 2'h0,
    ACR_CMD_WRITE   = 2'h1,
    ACR_CMD_READ    = 2'h2
  } acr_cmd_kind_type;

  typedef struct packed {
    logic             valid;
    acr_cmd_kind_type kind;
    logic [7:0]       page;
    logic [7:0]       data;
  } acr_cmd_type;

endpackage

//--- acr_host_model.sv
// Purpose: host side model that issues byte commands to the registers
// Assumes: commands change 1 ns after the rising edge of clk
// Notes:   a command stays up until the caller idles or replaces it
`timescale 1ns/1ns
`default_nettype none
module acr_host_model (
  input  wire logic                 clk,
  output var  acr_pkg::acr_cmd_type cmd,
  output var  logic [7:0]           book,
  output var  logic                 clk_en
);
  initial begin
    cmd    = '0;
    book   = 8'h00;
    clk_en = 1'b1;
  end
  // single clock, so audio clocks are settled before any write
  // no lock on the device side; sleep before changes is advisory
  // reserved bits are only ever written as zero
  task automatic op(input acr_pkg::acr_cmd_kind_type k,
                    input logic [7:0] pg, input logic [7:0] d);
    cmd = '{1'b1, k, pg, d};
    @(posedge clk);
    #1;
  endtask
  task automatic idle();
    cmd.valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // level inputs owned here so each has a single driver
  task automatic set_book(input logic [7:0] b);
    book = b;
  endtask
  task automatic set_en(input logic e);
    clk_en = e;
  endtask
endmodule
`default_nettype wire

//--- amp_core_control_regs_bench.sv
// Purpose: self-checking bench for the amplifier control registers
// Assumes: host model drives commands just after the rising edge
// Notes:   ramp checks only judge direction, the step phase is free
`timescale 1ns/1ns
`default_nettype none
module amp_core_control_regs_bench;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  acr_pkg::acr_cmd_type cmd;
  logic [7:0]           book, rdata, cur_page, cur_addr, gain, g, v;
  logic                 clk_en, rvalid, core_reset_pulse, bridge_config_bit;
  logic                 processor_reset_bit, mute_req, page_wrap_bit;
  logic [2:0]           switching_frequency_field;
  logic [1:0]           modulation_field, power_state;
  wire  [7:0]           cfg_view, pwr_view;
  int                   fail_count = 0;
  int                   samples_checked = 0;
  assign cfg_view = {1'b0, switching_frequency_field, 1'b0,
                     bridge_config_bit, modulation_field};
  assign pwr_view = {3'h0, processor_reset_bit, mute_req, 1'b0, power_state};
  always #5 clk = ~clk;
  acr_host_model i_host (.clk(clk), .cmd(cmd), .book(book), .clk_en(clk_en));
  acr_core_ctrl #(.GAIN_W(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cmd(cmd), .book(book),
    .rdata(rdata), .rvalid(rvalid), .cur_page(cur_page),
    .cur_addr(cur_addr), .core_reset_pulse(core_reset_pulse),
    .switching_frequency_field(switching_frequency_field),
    .bridge_config_bit(bridge_config_bit),
    .modulation_field(modulation_field),
    .processor_reset_bit(processor_reset_bit), .mute_req(mute_req),
    .power_state(power_state), .page_wrap_bit(page_wrap_bit), .gain(gain));
  task automatic check(input string what, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_host.op(acr_pkg::ACR_CMD_SETADDR, 8'h00, a);
    i_host.op(acr_pkg::ACR_CMD_WRITE, 8'h00, d);
    i_host.idle();
  endtask
  task automatic rd(input logic [7:0] a, exp);
    i_host.op(acr_pkg::ACR_CMD_SETADDR, 8'h00, a);
    i_host.op(acr_pkg::ACR_CMD_READ, 8'h00, 8'h00);
    check("rvalid", {7'h0, rvalid}, 8'h01);
    check("rdata", rdata, exp);
    i_host.idle();
  endtask
  // one wrapping write at the last address of page 1 in a nonzero book
  task automatic edge_write();
    i_host.set_book(8'h05);
    i_host.op(acr_pkg::ACR_CMD_SETADDR, 8'h01, 8'h7f);
    i_host.op(acr_pkg::ACR_CMD_WRITE, 8'h00, 8'h00);
    i_host.idle();
    i_host.set_book(8'h00);
  endtask
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    check("pwr_rst", pwr_view, acr_pkg::ACR_RST_POWER);
    rd(acr_pkg::ACR_OFS_RESET, 8'h00);
    rd(acr_pkg::ACR_OFS_CONFIG, acr_pkg::ACR_RST_CONFIG);
    rd(acr_pkg::ACR_OFS_POWER, acr_pkg::ACR_RST_POWER);
    rd(acr_pkg::ACR_OFS_WRAP, acr_pkg::ACR_RST_WRAP);
    rd(8'h05, 8'h00);
    for (int i = 0; i < 5; i++) begin
      v = {1'b0, i[2:0], 1'b0, i[0], 2'(i % 3)};
      wr(acr_pkg::ACR_OFS_CONFIG, v);
      check("cfg", cfg_view, v);
      rd(acr_pkg::ACR_OFS_CONFIG, v);
    end
    for (int i = 0; i < 4; i++) begin
      v = {3'h0, i[1], i[0], 1'b0, i[1:0]};
      wr(acr_pkg::ACR_OFS_POWER, v);
      check("pwr", pwr_view, v);
    end
    wr(acr_pkg::ACR_OFS_POWER, 8'h03);
    g = gain;
    repeat (300) @(posedge clk);
    #1 check("gain_up", {7'h0, gain > g}, 8'h01);
    wr(acr_pkg::ACR_OFS_POWER, 8'h0b);
    g = gain;
    repeat (300) @(posedge clk);
    #1 check("gain_down", {7'h0, gain < g}, 8'h01);
    wr(acr_pkg::ACR_OFS_CONFIG, 8'h31);
    wr(acr_pkg::ACR_OFS_RESET, 8'h01);
    check("cfg_regrst", cfg_view, acr_pkg::ACR_RST_CONFIG);
    check("pwr_regrst", pwr_view, acr_pkg::ACR_RST_POWER);
    rd(acr_pkg::ACR_OFS_RESET, 8'h00);
    wr(acr_pkg::ACR_OFS_CONFIG, 8'h31);
    i_host.op(acr_pkg::ACR_CMD_SETADDR, 8'h00, acr_pkg::ACR_OFS_RESET);
    i_host.op(acr_pkg::ACR_CMD_WRITE, 8'h00, 8'h10);
    check("core_pulse", {7'h0, core_reset_pulse}, 8'h01);
    check("cfg_corerst", cfg_view, acr_pkg::ACR_RST_CONFIG);
    i_host.idle();
    check("core_pulse_end", {7'h0, core_reset_pulse}, 8'h00);
    // enable low: a full write sequence must leave the register alone
    i_host.set_en(1'b0);
    wr(acr_pkg::ACR_OFS_CONFIG, 8'h31);
    check("cfg_frozen", cfg_view, acr_pkg::ACR_RST_CONFIG);
    i_host.set_en(1'b1);
    wr(acr_pkg::ACR_OFS_WRAP, 8'h08);
    check("wrap_bit", {7'h0, page_wrap_bit}, 8'h01);
    edge_write();
    check("addr_same", cur_addr, acr_pkg::ACR_PAGE_FIRST);
    check("page_same", cur_page, 8'h01);
    wr(acr_pkg::ACR_OFS_WRAP, 8'h00);
    edge_write();
    check("addr_next", cur_addr, acr_pkg::ACR_PAGE_RESTART);
    check("page_next", cur_page, 8'h02);
    print_verdict();
  end
endmodule
`default_nettype wire
